// ===== logic/mcs_pkg.sv
package mcs_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] MCS_ADDR_CTRL     = 4'h0;
  localparam logic [3:0] MCS_ADDR_CAPCTRL  = 4'h1;
  localparam logic [3:0] MCS_ADDR_VREF     = 4'h2;
  localparam logic [3:0] MCS_ADDR_MASK     = 4'h3;
  localparam logic [3:0] MCS_ADDR_STATUS   = 4'h4;
  localparam logic [3:0] MCS_ADDR_LIMIT    = 4'h5;
  localparam logic [3:0] MCS_ADDR_LATCH_LO = 4'h6;
  localparam logic [3:0] MCS_ADDR_LATCH_HI = 4'h7;
  localparam logic [3:0] MCS_ADDR_LIMIT_HI_RD = 4'h8;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MCS_CTRL_START_BIT  = 0;
  localparam int MCS_CTRL_STAGE_LSB  = 1;
  localparam int MCS_CTRL_MOTION_BIT = 3;
  localparam int MCS_MASK_IRQ_BIT    = 0;
  localparam int MCS_STAT_FLAG_BIT   = 0;
  localparam int MCS_STAT_STATE_BIT  = 1;
  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  MCS_RST_BYTE  = 8'h00;
  localparam logic [15:0] MCS_RST_WORD  = 16'h0000;
  localparam logic [1:0]  MCS_STAGE_OFF = 2'h0;
  localparam logic [1:0]  MCS_STAGE_CAP = 2'h1;
  localparam logic [1:0]  MCS_STAGE_VLT = 2'h3;
  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam logic [3:0] MCS_SETTLE_CYC = 4'h4;
  localparam logic [7:0] MCS_GND_PERIOD = 8'hff;
  localparam logic [7:0] MCS_GND_LEN    = 8'h08;

  typedef enum logic [1:0] {
    MCS_M_IDLE   = 2'b00,
    MCS_M_SETTLE = 2'b01,
    MCS_M_SAMPLE = 2'b10
  } mcs_mstate_t;
endpackage

// ===== logic/mcs_sensor_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_sensor_ctrl
  import mcs_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Processor side
  input  wire logic        global_irq_enable,
  input  wire logic        motion_vector_ack,
  output logic             sensor_irq,
  // Timer side
  input  wire logic        sensor_tick_clock,
  input  wire logic        measure_clk_tick,
  // Analog front end
  input  wire logic        motion_comp_out,
  input  wire logic        cap_comp_out,
  output logic             divider_switch,
  output logic      [7:0]  vref_trim,
  output logic             cap_unit_enable,
  output logic             volt_unit_enable,
  output logic      [2:0]  cap_channel_select,
  output logic      [1:0]  charge_current_select,
  output logic             sensor_pins_ground,
  output logic             cap_discharge,
  output logic             sensor_pulse_out,
  output logic             measure_busy
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]  sensor_control_reg;
  logic [7:0]  cap_control_reg;
  logic        motion_irq_enable;
  logic        motion_edge_flag;
  logic        motion_detect_line;
  logic [15:0] compare_counter_limit;
  logic [15:0] capture_timer_latch;
  logic        motion_unit_enable;
  logic [1:0]  stage_select;
  logic        wr_ctrl;
  logic        start_pulse;

  assign motion_unit_enable = sensor_control_reg[MCS_CTRL_MOTION_BIT];
  assign stage_select = sensor_control_reg[MCS_CTRL_STAGE_LSB +: 2];
  assign wr_ctrl = reg_wr && (reg_addr == MCS_ADDR_CTRL);
  assign start_pulse = wr_ctrl && reg_wdata[MCS_CTRL_START_BIT];
  assign cap_channel_select = cap_control_reg[5:3];
  assign charge_current_select = cap_control_reg[1:0];
  assign cap_unit_enable = (stage_select == MCS_STAGE_CAP);
  assign volt_unit_enable = (stage_select == MCS_STAGE_VLT);

  logic match;
  logic [15:0] pulse_count;
  logic [15:0] capture_timer;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sensor_control_reg <= MCS_RST_BYTE;
    end else if (wr_ctrl) begin
      sensor_control_reg <= {4'h0, reg_wdata[3:0]};
    end else if (match) begin
      sensor_control_reg[MCS_CTRL_START_BIT] <= 1'b0;
    end
  end
  assign measure_busy = sensor_control_reg[MCS_CTRL_START_BIT];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cap_control_reg       <= MCS_RST_BYTE;
      vref_trim             <= MCS_RST_BYTE;
      motion_irq_enable     <= 1'b0;
      compare_counter_limit <= MCS_RST_WORD;
    end else if (reg_wr) begin
      if (reg_addr == MCS_ADDR_CAPCTRL)
        cap_control_reg <= {2'h0, reg_wdata[5:0]};
      if (reg_addr == MCS_ADDR_VREF)
        vref_trim <= reg_wdata;
      if (reg_addr == MCS_ADDR_MASK)
        motion_irq_enable <= reg_wdata[MCS_MASK_IRQ_BIT];
      if (reg_addr == MCS_ADDR_LIMIT)
        compare_counter_limit[7:0] <= reg_wdata;
      if (reg_addr == MCS_ADDR_LIMIT + 4'h1)
        compare_counter_limit[15:8] <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Pin ground schedule and motion state machine
  // ---------------------------------------------------------------
  logic [7:0] gnd_cnt;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gnd_cnt <= MCS_RST_BYTE;
    end else if (!cap_unit_enable) begin
      gnd_cnt <= MCS_RST_BYTE;
    end else if (gnd_cnt == MCS_GND_PERIOD) begin
      gnd_cnt <= MCS_RST_BYTE;
    end else begin
      gnd_cnt <= gnd_cnt + 8'h01;
    end
  end
  assign sensor_pins_ground = cap_unit_enable && (gnd_cnt < MCS_GND_LEN);

  // Tick and comparator come from other domains, so two stages each
  logic [1:0] tick_sync;
  logic [1:0] comp_sync;
  logic       tick_prev;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_sync <= 2'h0;
      comp_sync <= 2'h0;
      tick_prev <= 1'b0;
    end else begin
      tick_sync <= {tick_sync[0], sensor_tick_clock};
      comp_sync <= {comp_sync[0], motion_comp_out};
      tick_prev <= tick_sync[1];
    end
  end
  logic tick_rise;
  assign tick_rise = tick_sync[1] && !tick_prev;

  mcs_mstate_t mstate;
  mcs_mstate_t next_mstate;
  logic [3:0]  settle_cnt;

  always_comb begin
    next_mstate = mstate;
    unique case (mstate)
      MCS_M_IDLE:
        if (tick_rise) next_mstate = MCS_M_SETTLE;
      MCS_M_SETTLE:
        if (settle_cnt == MCS_SETTLE_CYC) next_mstate = MCS_M_SAMPLE;
      MCS_M_SAMPLE:
        next_mstate = MCS_M_IDLE;
      default:
        next_mstate = MCS_M_IDLE;
    endcase
    // Disabling forces a clean restart, so a timer change mid-cycle is safe
    if (!motion_unit_enable) next_mstate = MCS_M_IDLE;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mstate     <= MCS_M_IDLE;
      settle_cnt <= 4'h0;
    end else begin
      mstate     <= next_mstate;
      settle_cnt <= (mstate == MCS_M_SETTLE) ? settle_cnt + 4'h1 : 4'h0;
    end
  end
  assign divider_switch = (mstate != MCS_M_IDLE);

  // Sample held between measurements; grounded pins give no detection
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      motion_detect_line <= 1'b0;
    end else if (!motion_unit_enable) begin
      motion_detect_line <= 1'b0;
    end else if (mstate == MCS_M_SAMPLE) begin
      motion_detect_line <= comp_sync[1] && !sensor_pins_ground;
    end
  end

  logic line_prev;
  logic line_rise;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) line_prev <= 1'b0;
    else       line_prev <= motion_detect_line;
  end
  assign line_rise = motion_detect_line && !line_prev;

  logic flag_clr;
  assign flag_clr = motion_vector_ack ||
                    (reg_wr && reg_addr == MCS_ADDR_STATUS &&
                     reg_wdata[MCS_STAT_FLAG_BIT]);
  // Set beats clear so an edge in the clearing cycle is kept
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)          motion_edge_flag <= 1'b0;
    else if (line_rise) motion_edge_flag <= 1'b1;
    else if (flag_clr)  motion_edge_flag <= 1'b0;
  end
  assign sensor_irq = motion_edge_flag && motion_irq_enable &&
                      global_irq_enable;

  // ---------------------------------------------------------------
  // Capacitance converter
  // ---------------------------------------------------------------
  logic [2:0] cap_sync;
  logic       run;
  assign run = measure_busy && cap_unit_enable;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cap_sync <= 3'h0;
    else       cap_sync <= {cap_sync[1:0], cap_comp_out};
  end
  // Threshold crossing ends charge; one-cycle discharge forms each pulse
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) sensor_pulse_out <= 1'b0;
    else       sensor_pulse_out <= run && cap_sync[1] && !cap_sync[2];
  end
  assign cap_discharge = sensor_pulse_out || !run;

  assign match = run && sensor_pulse_out &&
                 (pulse_count + 16'h0001 == compare_counter_limit);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_count   <= MCS_RST_WORD;
      capture_timer <= MCS_RST_WORD;
    end else if (start_pulse) begin
      pulse_count   <= MCS_RST_WORD;
      capture_timer <= MCS_RST_WORD;
    end else if (run) begin
      if (sensor_pulse_out) pulse_count <= pulse_count + 16'h0001;
      if (measure_clk_tick) capture_timer <= capture_timer + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)      capture_timer_latch <= MCS_RST_WORD;
    else if (match) capture_timer_latch <= capture_timer;
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= MCS_RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        MCS_ADDR_CTRL:     reg_rdata <= sensor_control_reg;
        MCS_ADDR_CAPCTRL:  reg_rdata <= cap_control_reg;
        MCS_ADDR_VREF:     reg_rdata <= vref_trim;
        MCS_ADDR_MASK:     reg_rdata <= {7'h00, motion_irq_enable};
        MCS_ADDR_STATUS:   reg_rdata <= {6'h00, motion_detect_line,
                                         motion_edge_flag};
        MCS_ADDR_LIMIT:    reg_rdata <= compare_counter_limit[7:0];
        MCS_ADDR_LIMIT_HI_RD: reg_rdata <= compare_counter_limit[15:8];
        MCS_ADDR_LATCH_LO: reg_rdata <= capture_timer_latch[7:0];
        MCS_ADDR_LATCH_HI: reg_rdata <= capture_timer_latch[15:8];
        default:           reg_rdata <= MCS_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= MCS_RST_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_tick;
    tick_rise && motion_unit_enable && mstate == MCS_M_IDLE;
  endsequence
  chk_motion_off_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    !motion_unit_enable |=> !divider_switch)
    else $error("motion unit active while disabled");
  chk_tick_launch: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_tick ##1 motion_unit_enable |-> divider_switch)
    else $error("tick did not close divider switch");
  chk_switch_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(divider_switch) |-> (divider_switch [*6] ##1 !divider_switch)
      or (##[0:5] !motion_unit_enable))
    else $error("divider switch length wrong");
  chk_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    line_rise |=> motion_edge_flag)
    else $error("edge flag not set");
  chk_flag_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    flag_clr && !line_rise |=> !motion_edge_flag)
    else $error("edge flag not cleared");
  chk_irq_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    line_rise ##1 motion_irq_enable && global_irq_enable |->
      sensor_irq)
    else $error("interrupt gating wrong");
  chk_status_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == MCS_ADDR_STATUS |=>
      reg_rdata[7:2] == 6'h00 &&
      reg_rdata[1] == $past(motion_detect_line))
    else $error("status read wrong");
  chk_match_stop: assert property (@(posedge ref_clk) disable iff (!nrst)
    match && !wr_ctrl |=> !measure_busy &&
      capture_timer_latch == $past(capture_timer))
    else $error("match did not stop and latch");
  chk_start_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    start_pulse |=> capture_timer == 16'h0000 &&
      pulse_count == 16'h0000)
    else $error("counters not restarted together");
  sequence s_sample_grounded;
    mstate == MCS_M_SAMPLE && motion_unit_enable && sensor_pins_ground;
  endsequence
  chk_ground_mask: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_sample_grounded |=> !motion_detect_line)
    else $error("motion detected while pins grounded");
  sequence s_line_rise;
    $rose(motion_detect_line);
  endsequence
  chk_sync_path: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_line_rise |-> $past(comp_sync[1]) &&
      !$past(sensor_pins_ground))
    else $error("detect line rose without synced comparator");
  chk_sync_depth: assert property (@(posedge ref_clk) disable iff (!nrst)
    comp_sync[1] == $past(motion_comp_out, 2))
    else $error("comparator synchroniser depth wrong");
  chk_cap_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cap_unit_enable |-> !sensor_pins_ground && cap_discharge)
    else $error("capacitance unit active while off");
  chk_cap_no_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cap_unit_enable |=> !sensor_pulse_out)
    else $error("pulse out while capacitance unit off");
endmodule
`default_nettype wire

// ===== sim/mcs_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_sensor_model #(
  parameter int CHARGE = 6
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Motion pin
  input  wire logic [7:0] pin_level,
  input  wire logic [7:0] vref_trim,
  input  wire logic       divider_switch,
  output logic            motion_comp_out,
  // Capacitance ramp
  input  wire logic       cap_unit_enable,
  input  wire logic       cap_discharge,
  input  wire logic       sensor_pins_ground,
  output logic            cap_comp_out
);
  logic [7:0] charge_cnt;
  // ------------------------------------------------------------
  // Divider comparator
  // ------------------------------------------------------------
  // Open divider leaves the comparator meaningless: toggle, never hold
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      motion_comp_out <= 1'b0;
    else if (divider_switch)
      motion_comp_out <= (pin_level < vref_trim);
    else
      motion_comp_out <= ~motion_comp_out;
  end
  // ------------------------------------------------------------
  // Charge ramp
  // ------------------------------------------------------------
  // Grounded or discharged plates restart the ramp from zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      charge_cnt <= 8'h00;
    else if (!cap_unit_enable || cap_discharge || sensor_pins_ground)
      charge_cnt <= 8'h00;
    else if (charge_cnt < CHARGE[7:0])
      charge_cnt <= charge_cnt + 8'h01;
  end
  assign cap_comp_out = (charge_cnt == CHARGE[7:0]);
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mcs_pkg::*;
  logic       ref_clk = 1'b0, nrst = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, vref_trim, pin_level, d;
  logic       reg_wr, reg_rd, global_irq_enable, motion_vector_ack;
  logic       sensor_irq, sensor_tick_clock;
  logic       measure_clk_tick = 1'b0;
  logic       motion_comp_out, cap_comp_out, divider_switch;
  logic       cap_unit_enable, volt_unit_enable, sensor_pins_ground;
  logic       cap_discharge, sensor_pulse_out, measure_busy;
  logic [2:0] cap_channel_select;
  logic [1:0] charge_current_select;
  int         fail_count = 0, checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) measure_clk_tick <= ~measure_clk_tick;
  mcs_sensor_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_irq_enable(global_irq_enable),
    .motion_vector_ack(motion_vector_ack), .sensor_irq(sensor_irq),
    .sensor_tick_clock(sensor_tick_clock),
    .measure_clk_tick(measure_clk_tick),
    .motion_comp_out(motion_comp_out), .cap_comp_out(cap_comp_out),
    .divider_switch(divider_switch), .vref_trim(vref_trim),
    .cap_unit_enable(cap_unit_enable),
    .volt_unit_enable(volt_unit_enable),
    .cap_channel_select(cap_channel_select),
    .charge_current_select(charge_current_select),
    .sensor_pins_ground(sensor_pins_ground),
    .cap_discharge(cap_discharge), .sensor_pulse_out(sensor_pulse_out),
    .measure_busy(measure_busy));
  mcs_sensor_model model_u (.ref_clk(ref_clk), .nrst(nrst),
    .pin_level(pin_level), .vref_trim(vref_trim),
    .divider_switch(divider_switch), .motion_comp_out(motion_comp_out),
    .cap_unit_enable(cap_unit_enable), .cap_discharge(cap_discharge),
    .sensor_pins_ground(sensor_pins_ground),
    .cap_comp_out(cap_comp_out));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, "register read");
  endtask
  // One sensor tick; counts cycles with the divider closed
  task automatic tick(output int sw);
    sw = 0;
    @(posedge ref_clk) sensor_tick_clock <= 1'b1;
    repeat (24) begin
      @(posedge ref_clk);
      #1 sw += (divider_switch === 1'b1);
    end
    @(posedge ref_clk) sensor_tick_clock <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdchk(MCS_ADDR_VREF, 8'h00);
    rdchk(MCS_ADDR_STATUS, 8'h00);
    rdchk(4'hf, 8'h00);
    wr(MCS_ADDR_VREF, 8'ha5);
    rdchk(MCS_ADDR_VREF, 8'ha5);
    chk(vref_trim, 8'ha5, "trim output");
    wr(MCS_ADDR_MASK, 8'hff);
    rdchk(MCS_ADDR_MASK, 8'h01);
    wr(MCS_ADDR_STATUS, 8'hfe);
    rdchk(MCS_ADDR_STATUS, 8'h00);
    wr(MCS_ADDR_CAPCTRL, 8'hff);
    rdchk(MCS_ADDR_CAPCTRL, 8'h3f);
    chk(cap_channel_select, 3'h7, "channel select");
    chk(charge_current_select, 2'h3, "current select");
  endtask
  task automatic t_motion;
    int sw;
    tick(sw);
    chk(sw == 0, 1'b1, "switch while disabled");
    rdchk(MCS_ADDR_STATUS, 8'h00);
    wr(MCS_ADDR_CTRL, 8'h08);
    tick(sw);
    chk(sw > 0, 1'b1, "switch closed");
    rdchk(MCS_ADDR_STATUS, 8'h03);
    chk(sensor_irq, 1'b1, "irq raised");
    @(posedge ref_clk) global_irq_enable <= 1'b0;
    @(posedge ref_clk) #1 chk(sensor_irq, 1'b0, "irq global off");
    @(posedge ref_clk) global_irq_enable <= 1'b1;
    wr(MCS_ADDR_MASK, 8'h00);
    chk(sensor_irq, 1'b0, "irq masked");
    wr(MCS_ADDR_MASK, 8'h01);
    wr(MCS_ADDR_STATUS, 8'h00);
    rdchk(MCS_ADDR_STATUS, 8'h03);
    wr(MCS_ADDR_STATUS, 8'h01);
    rdchk(MCS_ADDR_STATUS, 8'h02);
    @(posedge ref_clk) pin_level <= 8'hff;
    tick(sw);
    rdchk(MCS_ADDR_STATUS, 8'h00);
    @(posedge ref_clk) pin_level <= 8'h00;
    tick(sw);
    rdchk(MCS_ADDR_STATUS, 8'h03);
    @(posedge ref_clk) motion_vector_ack <= 1'b1;
    @(posedge ref_clk) motion_vector_ack <= 1'b0;
    rdchk(MCS_ADDR_STATUS, 8'h02);
  endtask
  task automatic t_stage;
    int n, sw;
    for (int c = 0; c < 4; c++) begin
      wr(MCS_ADDR_CTRL, 8'(c << 1));
      chk(cap_unit_enable, c == 1, "cap enable");
      chk(volt_unit_enable, c == 3, "volt enable");
    end
    wr(MCS_ADDR_CTRL, 8'h0a);
    for (n = 0; n < 600 && sensor_pins_ground !== 1'b1; n++)
      @(posedge ref_clk) #1;
    if (n == 600) begin
      fail_count++;
      end_sim();
    end
    chk(sensor_pins_ground, 1'b1, "pins grounded");
    // Tick sample lands eight cycles after the tick, inside the next window
    repeat (249) @(posedge ref_clk);
    tick(sw);
    chk(sw > 0, 1'b1, "switch closed while grounded");
    rdchk(MCS_ADDR_STATUS, 8'h00);
    tick(sw);
    rdchk(MCS_ADDR_STATUS, 8'h03);
  endtask
  task automatic t_cap;
    int n, bsy, tk;
    logic last;
    logic [7:0] chan [3] = '{8'h18, 8'h38, 8'h00};
    wr(MCS_ADDR_LIMIT, 8'h03);
    wr(MCS_ADDR_LIMIT + 4'h1, 8'h00);
    rdchk(MCS_ADDR_LIMIT, 8'h03);
    // Two references, then the sensor channel
    for (int m = 0; m < 3; m++) begin
      n = 0;
      bsy = 0;
      tk = 0;
      last = 1'b0;
      wr(MCS_ADDR_CAPCTRL, chan[m]);
      wr(MCS_ADDR_CTRL, 8'h03);
      chk(measure_busy, 1'b1, "started");
      // Timer counts ticks from start up to the match cycle, not after
      while (measure_busy === 1'b1 && bsy < 3000) begin
        n += (sensor_pulse_out === 1'b1);
        tk += last;
        last = measure_clk_tick;
        bsy++;
        @(posedge ref_clk) #1;
      end
      if (bsy == 3000) begin
        fail_count++;
        end_sim();
      end
      chk(n, 3, "pulse count");
      chk(measure_busy, 1'b0, "stopped at limit");
      rdchk(MCS_ADDR_LATCH_LO, 8'(tk));
      rdchk(MCS_ADDR_LATCH_HI, 8'h00);
    end
    wr(MCS_ADDR_LIMIT + 4'h1, 8'hff);
    wr(MCS_ADDR_CTRL, 8'h03);
    repeat (20) @(posedge ref_clk);
    #1 chk(measure_busy, 1'b1, "still running");
    wr(MCS_ADDR_CTRL, 8'h02);
    chk(measure_busy, 1'b0, "stopped by zero");
    chk(cap_discharge, 1'b1, "discharged when stopped");
    wr(MCS_ADDR_CTRL, 8'h00);
    chk(cap_unit_enable, 1'b0, "off before sleep");
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {motion_vector_ack, sensor_tick_clock} = '0;
    global_irq_enable = 1'b1;
    pin_level = 8'h00;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_motion();
    t_stage();
    t_cap();
    end_sim();
  end
endmodule
`default_nettype wire
